// ### hdl/esr_status_regs.v
// Exception cause detail, delay-slot branch target and floating-point status
//
// How it works
// - Instruction bus error: first detail bit marks instruction local bus memory error.
// - Data bus error: first detail bit marks data local bus memory error.
// - Divide exception: division cause 0 for divide by zero, 1 for overflow.
// - Stream exception: low four detail bits hold stream index, rest reserved zero.
// - Data storage: zone fault bit set when zone protection caused fault.
// - Data storage: write bit set when faulting access was a store.
// - Instruction storage: zone fault bit only, other detail bits zero.
// - Data miss: write bit for stores, first detail bit kept zero.
// - Branch target register exists only when exception support is configured.
// - Delay-slot branch targets captured only while exception in progress is clear.
// - Branch target is read-only, selector 0x000B, resets to zero.
// - Branch target width follows address size in 64-bit mode, else 32.
// - Floating-point status at selector 0x0007, readable and writable.
// - Floating-point flags set by hardware or by software write, cleared only by software write.
// - Flags sit at word low end: invalid, zero divide, overflow, underflow, denormal.
// - Delay slot flag reads one when exception came from a delay slot.
`timescale 1ns/10ps
`default_nettype none
`include "esr_consts.vh"

module esr_status_regs #(
	parameter DATA_W     = 32,
	parameter ADDR_W     = 32,
	parameter USE_EXCEPT = 1
) (
	input  wire                       clock,
	input  wire                       rst_n,
	// Exception report from the pipeline
	input  wire                       exc_valid,
	input  wire [`ESR_EC_W-1:0]       exc_cause,
	input  wire                       exc_in_delay_slot,
	input  wire                       exc_mem_error,
	input  wire                       exc_div_overflow,
	input  wire [`ESR_CD_STREAM_W-1:0] exc_stream_index,
	input  wire                       exc_zone_fault,
	input  wire                       exc_store,
	input  wire                       exc_in_progress,
	// Delay-slot branch execution
	input  wire                       branch_delay_valid,
	input  wire [ADDR_W-1:0]          branch_target_addr,
	// Floating-point flag events, one bit per flag
	input  wire [`ESR_FP_N-1:0]       fp_flag_set,
	// Special-register access
	input  wire                       move_from_special,
	input  wire                       move_to_special,
	input  wire [`ESR_SEL_W-1:0]      special_reg_select,
	input  wire [DATA_W-1:0]          special_wr_data,
	output reg  [DATA_W-1:0]          special_rd_data,
	output reg                        special_rd_valid,
	output reg  [`ESR_CD_W-1:0]       cause_detail,
	output reg                        delay_slot_flag,
	output reg  [`ESR_FP_N-1:0]       fp_status
);

	// --------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------
	// Branch target is address-wide only in the 64-bit configuration
	localparam BT_W = (DATA_W == 64) ? ((ADDR_W > 64) ? 64 : ADDR_W) : 32;

	// --------------------------------------------------------------
	// Cause detail
	// --------------------------------------------------------------
	reg [`ESR_CD_W-1:0] detail_d;

	always @* begin
		detail_d = {`ESR_CD_W{1'b0}};
		case (exc_cause)
			`ESR_EC_IBUS: begin
				detail_d[`ESR_CD_FIRST] = exc_mem_error;
			end
			`ESR_EC_DBUS: begin
				detail_d[`ESR_CD_FIRST] = exc_mem_error;
			end
			`ESR_EC_DIVIDE: begin
				detail_d[`ESR_CD_FIRST] = exc_div_overflow;
			end
			`ESR_EC_STREAM: begin
				detail_d[`ESR_CD_STREAM_LSB +: `ESR_CD_STREAM_W] = exc_stream_index;
			end
			`ESR_EC_DSTORE: begin
				detail_d[`ESR_CD_FIRST] = exc_zone_fault;
				detail_d[`ESR_CD_WRITE] = exc_store;
			end
			`ESR_EC_ISTORE: begin
				detail_d[`ESR_CD_FIRST] = exc_zone_fault;
			end
			`ESR_EC_DMISS: begin
				detail_d[`ESR_CD_WRITE] = exc_store;
			end
			default: begin
				detail_d = {`ESR_CD_W{1'b0}};
			end
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			cause_detail    <= {`ESR_CD_W{1'b0}};
			delay_slot_flag <= 1'b0;
		end else if (exc_valid) begin
			cause_detail    <= detail_d;
			delay_slot_flag <= exc_in_delay_slot;
		end
	end

	// --------------------------------------------------------------
	// Branch target
	// --------------------------------------------------------------
	wire [BT_W-1:0] bt_value;

	generate
		if (USE_EXCEPT != 0) begin : g_bt
			reg [BT_W-1:0] bt_q;
			always @(posedge clock) begin
				if (!rst_n) begin
					bt_q <= {BT_W{1'b0}};
				end else if (branch_delay_valid && !exc_in_progress) begin
					bt_q <= branch_target_addr[BT_W-1:0];
				end
			end
			assign bt_value = bt_q;
		end else begin : g_no_bt
			assign bt_value = {BT_W{1'b0}};
		end
	endgenerate

	// --------------------------------------------------------------
	// Floating-point status
	// --------------------------------------------------------------
	wire                 fp_wr;
	wire [`ESR_FP_N-1:0] fp_flags;

	assign fp_wr = move_to_special && (special_reg_select == `ESR_SEL_FP_STATUS);

	esr_sticky_bits #(
		.N (`ESR_FP_N)
	) u_fp_flags (
		.clock    (clock),
		.rst_n    (rst_n),
		.set_bits (fp_flag_set),
		.wr_en    (fp_wr),
		.wr_data  (special_wr_data[`ESR_FP_N-1:0]),
		.flags    (fp_flags)
	);

	always @(posedge clock) begin
		if (!rst_n) begin
			fp_status <= {`ESR_FP_N{1'b0}};
		end else begin
			fp_status <= fp_flags;
		end
	end

	// --------------------------------------------------------------
	// Special-register read
	// --------------------------------------------------------------
	// Branch target write attempts fall through: register is read-only
	reg [DATA_W-1:0] rd_d;
	reg              hit_d;

	always @* begin
		rd_d  = {DATA_W{1'b0}};
		hit_d = 1'b0;
		case (special_reg_select)
			`ESR_SEL_FP_STATUS: begin
				// Flags share the low end of the word with the write data
				rd_d[`ESR_FP_N-1:0] = fp_flags;
				hit_d = 1'b1;
			end
			`ESR_SEL_BRANCH_TARGET: begin
				rd_d[BT_W-1:0] = bt_value;
				hit_d = (USE_EXCEPT != 0);
			end
			default: begin
				hit_d = 1'b0;
			end
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			special_rd_data  <= {DATA_W{1'b0}};
			special_rd_valid <= 1'b0;
		end else begin
			special_rd_valid <= move_from_special && hit_d;
			if (move_from_special) begin
				special_rd_data <= rd_d;
			end
		end
	end

endmodule // esr_status_regs

`default_nettype wire

// ### hdl/esr_consts.vh
// Constants for the exception status block
`ifndef ESR_CONSTS_VH
`define ESR_CONSTS_VH

// Special-register selector codes
`define ESR_SEL_FP_STATUS      16'h0007
`define ESR_SEL_BRANCH_TARGET  16'h000B
`define ESR_SEL_W              16

// Exception cause codes
`define ESR_EC_W               5
`define ESR_EC_STREAM          5'h00
`define ESR_EC_ILLEGAL         5'h02
`define ESR_EC_IBUS            5'h03
`define ESR_EC_DBUS            5'h04
`define ESR_EC_DIVIDE          5'h05
`define ESR_EC_FPU             5'h06
`define ESR_EC_PRIV            5'h07
`define ESR_EC_STACK           5'h07
`define ESR_EC_DSTORE          5'h10
`define ESR_EC_ISTORE          5'h11
`define ESR_EC_DMISS           5'h12
`define ESR_EC_IMISS           5'h13

// Cause-detail field, seven bits, index 0 = most significant documented bit
`define ESR_CD_W               7
`define ESR_CD_FIRST           6
`define ESR_CD_WRITE           5
`define ESR_CD_STREAM_LSB      0
`define ESR_CD_STREAM_W        4

// Floating-point status flags, counted from the low end of the word
`define ESR_FP_N               5
`define ESR_FP_INVALID         4
`define ESR_FP_ZERO_DIV        3
`define ESR_FP_OVERFLOW        2
`define ESR_FP_UNDERFLOW       1
`define ESR_FP_DENORM          0

`endif

// ### hdl/esr_sticky_bits.v
// Sticky flag bank: hardware sets, software writes
`timescale 1ns/10ps
`default_nettype none

module esr_sticky_bits #(
	parameter N = 5
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire [N-1:0] set_bits,
	input  wire         wr_en,
	input  wire [N-1:0] wr_data,
	output wire [N-1:0] flags
);

	reg [N-1:0] flags_q;

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_flag
			always @(posedge clock) begin
				if (!rst_n) begin
					flags_q[i] <= 1'b0;
				// Set wins over a clearing write in the same cycle
				end else if (set_bits[i]) begin
					flags_q[i] <= 1'b1;
				end else if (wr_en) begin
					flags_q[i] <= wr_data[i];
				end
			end
		end
	endgenerate

	assign flags = flags_q;

endmodule // esr_sticky_bits

`default_nettype wire

// ### dv/esr_status_sva.sv
// Checker for the exception status block ports
`timescale 1ns/10ps
`default_nettype none
module esr_status_sva #(
	parameter DATA_W = 32
) (
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic              exc_valid,
	input wire logic [4:0]        exc_cause,
	input wire logic              exc_in_delay_slot,
	input wire logic              exc_mem_error,
	input wire logic              exc_div_overflow,
	input wire logic [3:0]        exc_stream_index,
	input wire logic              exc_zone_fault,
	input wire logic              exc_store,
	input wire logic [4:0]        fp_flag_set,
	input wire logic              move_from_special,
	input wire logic              move_to_special,
	input wire logic [15:0]       special_reg_select,
	input wire logic [DATA_W-1:0] special_rd_data,
	input wire logic              special_rd_valid,
	input wire logic [6:0]        cause_detail,
	input wire logic              delay_slot_flag,
	input wire logic [4:0]        fp_status
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire ev = exc_valid;
	a_ds_follows: assert property (ev |=> delay_slot_flag == $past(exc_in_delay_slot))
		else $error("delay slot flag wrong");
	a_bus_err: assert property (ev && (exc_cause == 5'h03 || exc_cause == 5'h04) |=>
		cause_detail == {$past(exc_mem_error), 6'h00}) else $error("bus error detail wrong");
	a_div_cause: assert property (ev && exc_cause == 5'h05 |=>
		cause_detail == {$past(exc_div_overflow), 6'h00}) else $error("divide detail wrong");
	a_stream_idx: assert property (ev && exc_cause == 5'h00 |=>
		cause_detail == {3'h0, $past(exc_stream_index)}) else $error("stream detail wrong");
	a_dstore_bits: assert property (ev && exc_cause == 5'h10 |=>
		cause_detail == {$past(exc_zone_fault), $past(exc_store), 5'h00}) else $error("dstore detail wrong");
	a_istore_bits: assert property (ev && exc_cause == 5'h11 |=>
		cause_detail == {$past(exc_zone_fault), 6'h00}) else $error("istore detail wrong");
	a_dmiss_bits: assert property (ev && exc_cause == 5'h12 |=>
		cause_detail == {1'b0, $past(exc_store), 5'h00}) else $error("dmiss detail wrong");
	a_other_zero: assert property (ev && exc_cause inside {5'h02, 5'h06, 5'h07, 5'h13} |=>
		cause_detail == 7'h00) else $error("detail not zero");
	a_fp_sticky: assert property (($past(fp_status) & ~fp_status) != 5'h00 |->
		$past(move_to_special && special_reg_select == 16'h0007, 2)) else $error("flag cleared by hardware");
	a_fp_set: assert property (fp_flag_set != 5'h00 |-> ##2
		&(fp_status | ~$past(fp_flag_set, 2))) else $error("flag not set");
	a_fp_read: assert property (move_from_special && special_reg_select == 16'h0007 |=>
		special_rd_valid && special_rd_data[4:0] == fp_status) else $error("flag read wrong");
	cover property (ev && exc_in_delay_slot);
	cover property (fp_flag_set != 5'h00 && move_to_special);
	cover property (special_rd_valid);
endmodule // esr_status_sva
bind esr_status_regs esr_status_sva #(.DATA_W(DATA_W)) u_sva (.*);
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the exception status block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock = 1'b0, rst_n = 1'b0, exc_valid = 1'b0, exc_in_delay_slot = 1'b0;
	logic exc_mem_error = 1'b0, exc_div_overflow = 1'b0, exc_zone_fault = 1'b0, exc_store = 1'b0;
	logic exc_in_progress = 1'b0, branch_delay_valid = 1'b0, move_from_special = 1'b0, move_to_special = 1'b0;
	logic [4:0] exc_cause = 5'h00, fp_flag_set = 5'h00;
	logic [3:0] exc_stream_index = 4'h0;
	logic [15:0] special_reg_select = 16'h0000;
	logic [31:0] branch_target_addr = 32'h0, special_wr_data = 32'h0, special_rd_data;
	logic special_rd_valid, delay_slot_flag;
	logic rd_vld = 1'b0;
	logic [6:0] cause_detail;
	logic [4:0] fp_status;
	logic [4:0] oth [4] = '{5'h02, 5'h06, 5'h07, 5'h13};
	int errors = 0, num_checks = 0;
	esr_status_regs dut (.*);
	initial forever #50 clock = ~clock;
	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task rd(input logic [15:0] s);
		@(negedge clock) move_from_special = 1'b1;
		special_reg_select = s;
		@(negedge clock) move_from_special = 1'b0;
		// Valid stands one cycle only, so catch it here
		rd_vld = special_rd_valid;
		@(negedge clock);
	endtask
	task wr(input logic [15:0] s, input logic [31:0] d);
		@(negedge clock) move_to_special = 1'b1;
		special_reg_select = s;
		special_wr_data = d;
		@(negedge clock) move_to_special = 1'b0;
	endtask
	// Flag vector is {delay slot, mem error, overflow, zone, store}
	task ex(input logic [4:0] c, input logic [3:0] i, input logic [4:0] f, input logic [6:0] e);
		@(negedge clock) exc_valid = 1'b1;
		exc_cause = c;
		exc_stream_index = i;
		{exc_in_delay_slot, exc_mem_error, exc_div_overflow, exc_zone_fault, exc_store} = f;
		@(negedge clock) exc_valid = 1'b0;
		@(negedge clock) chk(cause_detail, e);
		chk(delay_slot_flag, f[4]);
	endtask
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task t_reset;
		rd(16'h000B);
		chk(rd_vld, 1'b1);
		chk(special_rd_data, 32'h0);
		rd(16'h0007);
		chk(rd_vld, 1'b1);
		chk(special_rd_data[4:0], 5'h00);
		chk(cause_detail, 7'h00);
		chk(delay_slot_flag, 1'b0);
		chk(fp_status, 5'h00);
	endtask
	task t_causes;
		ex(5'h03, 4'h0, 5'h1F, 7'h40);
		ex(5'h03, 4'hF, 5'h07, 7'h00);
		ex(5'h04, 4'h0, 5'h08, 7'h40);
		ex(5'h05, 4'hF, 5'h04, 7'h40);
		ex(5'h05, 4'hF, 5'h1B, 7'h00);
		ex(5'h00, 4'hA, 5'h1F, 7'h0A);
		ex(5'h10, 4'hF, 5'h03, 7'h60);
		ex(5'h10, 4'h0, 5'h09, 7'h20);
		ex(5'h11, 4'hF, 5'h0B, 7'h40);
		ex(5'h12, 4'hF, 5'h0B, 7'h20);
		for (int k = 0; k < 4; k++) ex(oth[k], 4'hF, 5'h1F, 7'h00);
	endtask
	// Second target arrives while an exception is in progress and must be dropped
	task t_branch;
		@(negedge clock) branch_delay_valid = 1'b1;
		branch_target_addr = 32'h89AB_CDEF;
		@(negedge clock) exc_in_progress = 1'b1;
		branch_target_addr = 32'h1234_5678;
		@(negedge clock) branch_delay_valid = 1'b0;
		exc_in_progress = 1'b0;
		// Delay-slot exception: the handler resumes at the captured target
		ex(5'h03, 4'h0, 5'h10, 7'h00);
		wr(16'h000B, 32'hFFFF_FFFF);
		rd(16'h000B);
		chk(rd_vld, 1'b1);
		chk(special_rd_data, 32'h89AB_CDEF);
	endtask
	task t_fp;
		@(negedge clock) fp_flag_set = 5'h12;
		@(negedge clock) fp_flag_set = 5'h00;
		repeat (2) @(negedge clock);
		chk(fp_status, 5'h12);
		rd(16'h0007);
		chk(special_rd_data[4:0], 5'h12);
		wr(16'h0007, 32'h10);
		rd(16'h0007);
		chk(special_rd_data[4:0], 5'h10);
		@(negedge clock) fp_flag_set = 5'h01;
		move_to_special = 1'b1;
		special_reg_select = 16'h0007;
		special_wr_data = 32'h0;
		@(negedge clock) fp_flag_set = 5'h00;
		move_to_special = 1'b0;
		rd(16'h0007);
		chk(special_rd_data[4:0], 5'h01);
		rd(16'h0005);
		chk(rd_vld, 1'b0);
		chk(special_rd_data, 32'h0);
	endtask
	initial begin
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		t_reset;
		t_causes;
		t_branch;
		t_fp;
		end_sim;
	end
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		end_sim;
	end
endmodule // tb
`default_nettype wire
